// [design/tcc_pkg.sv]
package tcc_pkg;

	// ------------------------------------------------------------
	// Register map and bus widths
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 16;

	localparam logic [2:0] ADDR_CTRL   = 3'h0;
	localparam logic [2:0] ADDR_PRESC  = 3'h1;
	localparam logic [2:0] ADDR_COUNT  = 3'h2;
	localparam logic [2:0] ADDR_PERIOD = 3'h3;
	localparam logic [2:0] ADDR_DUTY   = 3'h4;
	localparam logic [2:0] ADDR_STATUS = 3'h5;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_CC0_CAP  = 2;
	localparam int unsigned CTRL_CC1_CAP  = 3;
	localparam int unsigned CTRL_PTOG     = 4;
	localparam int unsigned CTRL_DTOG     = 5;
	localparam int unsigned CTRL_OSP_EN   = 6;
	localparam int unsigned CTRL_OSP_SW   = 7;

	localparam int unsigned PRE_CLK_LSB    = 0;
	localparam int unsigned PRE_EDGE_A_LSB = 2;
	localparam int unsigned PRE_EDGE_B_LSB = 4;

	localparam int unsigned ST_OVF = 0;
	localparam int unsigned ST_PIF = 1;
	localparam int unsigned ST_DIF = 2;
	localparam int unsigned ST_OUT = 3;

	// ------------------------------------------------------------
	// Reset values and constants
	// ------------------------------------------------------------
	localparam logic [15:0] CTRL_RST   = 16'h0000;
	localparam logic [15:0] PRESC_RST  = 16'h0000;
	localparam logic [15:0] CC_RST     = 16'h0000;
	localparam logic [15:0] COUNT_MAX  = 16'hffff;
	localparam logic [1:0]  CLK_SEL_EXT = 2'h3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		TCC_STOP, TCC_CS_TRIG, TCC_FREE, TCC_CS_MATCH
	} tcc_mode_t;

	typedef enum logic [1:0] {
		TCC_EDGE_FALL, TCC_EDGE_RISE, TCC_EDGE_NONE, TCC_EDGE_BOTH
	} tcc_edge_t;

	typedef enum logic [1:0] {
		TCC_OS_IDLE, TCC_OS_WAIT, TCC_OS_PULSE
	} tcc_os_t;

endpackage : tcc_pkg

// [design/tcc_timer.sv]
// Behaviour
// - Reading the counter never captures into the duty register.
// - While stopped, both trigger pins are ignored.
// - One-shot works only in free-running or trigger-a clear-and-start mode.
// - No one-shot in clear-on-period-match mode.
// - Trigger a as count source disables captures triggered by trigger a.
// - Both edges selected on trigger a: no capture on trigger a.
// - Capture latches on count-clock fall; irq on the next rise.
// - A register in compare mode does not capture.
// - Compare write near a match may miss that match.
// - Counter keeps counting while toggling and period irq are off.
// - Unsafe duty changes may toggle the output at each transfer.
// - Pin high after reset gives a rising edge at first enable.
// - Restart after a stop gives no spurious rising edge.
// - Filter samples on system clock for counting, count clock for capture; trigger b capture also samples on system clock while pin a counts.
// - Edge counts only after two equal consecutive samples.
// - Overflow flag sets when the counter wraps to zero.
// - Capture wins over a read of the capture register.
module tcc_timer
	import tcc_pkg::*;
(
	input  wire logic              CLK_SYS_I,
	input  wire logic              RST_N_I,
	input  wire logic [ADDR_W-1:0] ADDR_I,
	input  wire logic [DATA_W-1:0] WR_DATA_I,
	input  wire logic              WR_EN_I,
	input  wire logic              RD_EN_I,
	output logic      [DATA_W-1:0] RD_DATA_O,
	input  wire logic              TRIGGER_INPUT_A_I,
	input  wire logic              TRIGGER_INPUT_B_I,
	output logic                   TOGGLE_OUTPUT_PIN_O,
	output logic                   PERIOD_MATCH_IRQ_O,
	output logic                   DUTY_MATCH_IRQ_O
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic edge_hit(input logic [1:0] sel,
		input logic rise, input logic fall);
		tcc_edge_t e;
		e = tcc_edge_t'(sel);
		case (e)
			TCC_EDGE_FALL: edge_hit = fall;
			TCC_EDGE_RISE: edge_hit = rise;
			TCC_EDGE_BOTH: edge_hit = rise | fall;
			default:       edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [15:0] ctrl_ff,   nxt_ctrl;
	logic [15:0] presc_ff,  nxt_presc;
	logic [15:0] count_ff,  nxt_count;
	logic [15:0] period_ff, nxt_period;
	logic [15:0] duty_ff,   nxt_duty;
	logic        ovf_ff,    nxt_ovf;
	logic        pif_ff,    nxt_pif;
	logic        dif_ff,    nxt_dif;
	logic [5:0]  div_ff,    nxt_div;
	logic        cclk_ff,   nxt_cclk;
	logic        sa1_ff,    nxt_sa1;
	logic        sa2_ff,    nxt_sa2;
	logic        lva_ff,    nxt_lva;
	logic        sb1_ff,    nxt_sb1;
	logic        sb2_ff,    nxt_sb2;
	logic        lvb_ff,    nxt_lvb;
	logic        seen_ff,   nxt_seen;
	logic        c0p_ff,    nxt_c0p;
	logic        c1p_ff,    nxt_c1p;
	logic        c0i_ff,    nxt_c0i;
	logic        c1i_ff,    nxt_c1i;
	logic        out_ff,    nxt_out;
	logic        pirq_ff,   nxt_pirq;
	logic        dirq_ff,   nxt_dirq;
	logic [15:0] rd_ff,     nxt_rd;
	tcc_os_t     os_ff,     nxt_os;

	tcc_mode_t   mode;
	logic        running, ext, cur_clk, rise_c, fall_c, samp_a, samp_b;
	logic        rise_a, fall_a, rise_b, fall_b, ea, eb, cnt_tick;
	logic        fall_tick, rise_tick, cap0_set, cap1_set, c0_latch;
	logic        c1_latch, osp_ok, osp_trig, trig_clr, pm_raw, pm, dm;
	logic        ovf_set, wr_ctrl, wr_stat;

	// ------------------------------------------------------------
	// Count clock, input filters and edge detection
	// ------------------------------------------------------------
	always_comb begin
		mode    = tcc_mode_t'(ctrl_ff[CTRL_MODE_LSB +: 2]);
		running = (mode != TCC_STOP);
		ext     = (presc_ff[PRE_CLK_LSB +: 2] == CLK_SEL_EXT);
		nxt_div = div_ff + 6'h01;
		case (presc_ff[PRE_CLK_LSB +: 2])
			2'h0:    cur_clk = div_ff[0];
			2'h1:    cur_clk = div_ff[2];
			2'h2:    cur_clk = div_ff[4];
			default: cur_clk = 1'b0;
		endcase
		nxt_cclk = cur_clk;
		rise_c   = cur_clk & ~cclk_ff;
		fall_c   = ~cur_clk & cclk_ff;
		// Before the first start the filters hold at zero so a pin
		// pulled high shows one edge at start; later they track it
		// while stopped so a restart sees no edge
		samp_a = seen_ff & (~running | ext | rise_c);
		samp_b = seen_ff & (~running | ext | rise_c);
		nxt_sa1 = samp_a ? TRIGGER_INPUT_A_I : sa1_ff;
		nxt_sa2 = samp_a ? sa1_ff : sa2_ff;
		nxt_sb1 = samp_b ? TRIGGER_INPUT_B_I : sb1_ff;
		nxt_sb2 = samp_b ? sb1_ff : sb2_ff;
		nxt_lva = (sa1_ff == sa2_ff) ? sa1_ff : lva_ff;
		nxt_lvb = (sb1_ff == sb2_ff) ? sb1_ff : lvb_ff;
		rise_a  = nxt_lva & ~lva_ff;
		fall_a  = ~nxt_lva & lva_ff;
		rise_b  = nxt_lvb & ~lvb_ff;
		fall_b  = ~nxt_lvb & lvb_ff;
		nxt_seen = seen_ff | running;
		ea = running & edge_hit(presc_ff[PRE_EDGE_A_LSB +: 2],
			rise_a, fall_a);
		eb = running & edge_hit(presc_ff[PRE_EDGE_B_LSB +: 2],
			rise_b, fall_b);
		cnt_tick  = running & (ext ? ea : rise_c);
		fall_tick = ext | fall_c;
		rise_tick = ext | rise_c;
	end

	// ------------------------------------------------------------
	// Counter, compare, one-shot and captures
	// ------------------------------------------------------------
	always_comb begin
		osp_ok = ctrl_ff[CTRL_OSP_EN] &
			((mode == TCC_FREE) | (mode == TCC_CS_TRIG));
		wr_ctrl  = WR_EN_I & (ADDR_I == ADDR_CTRL);
		wr_stat  = WR_EN_I & (ADDR_I == ADDR_STATUS);
		osp_trig = osp_ok & (os_ff == TCC_OS_IDLE) &
			((wr_ctrl & WR_DATA_I[CTRL_OSP_SW]) |
			((mode == TCC_CS_TRIG) & ea));
		// Outside one-shot a trigger-a edge restarts the count in clear-and-start mode, unless pin a is the count source
		trig_clr = osp_trig | (~osp_ok & (mode == TCC_CS_TRIG) & ea & ~ext);
		pm_raw = (count_ff == period_ff);
		// A write landing on the match cycle compares old value
		pm = cnt_tick & ~ctrl_ff[CTRL_CC0_CAP] & pm_raw;
		dm = cnt_tick & ~ctrl_ff[CTRL_CC1_CAP] &
			(count_ff == duty_ff);
		ovf_set = cnt_tick & ~trig_clr & (count_ff == COUNT_MAX);
		nxt_count = count_ff;
		if (!running) begin
			nxt_count = '0;
		end else if (trig_clr) begin
			nxt_count = '0;
		end else if (cnt_tick) begin
			if ((mode == TCC_CS_MATCH) && pm_raw) begin
				nxt_count = '0;
			end else begin
				nxt_count = count_ff + 16'h0001;
			end
		end
		// Trigger b feeds the period register, trigger a the duty one
		cap0_set = eb & ctrl_ff[CTRL_CC0_CAP];
		cap1_set = ea & ctrl_ff[CTRL_CC1_CAP] & ~ext &
			(presc_ff[PRE_EDGE_A_LSB +: 2] != 2'(TCC_EDGE_BOTH));
		c0_latch = c0p_ff & fall_tick & running;
		c1_latch = c1p_ff & fall_tick & running;
		nxt_c0p = running & (cap0_set | (c0p_ff & ~fall_tick));
		nxt_c1p = running & (cap1_set | (c1p_ff & ~fall_tick));
		nxt_c0i = running & (c0_latch | (c0i_ff & ~rise_tick));
		nxt_c1i = running & (c1_latch | (c1i_ff & ~rise_tick));
		nxt_os  = os_ff;
		nxt_out = out_ff;
		if (!osp_ok) begin
			nxt_os = TCC_OS_IDLE;
			// Each enabled match toggles (period and duty in one cycle cancel), so a duty value that moves past the
			// count more than once flips the pin each time
			if ((pm && ctrl_ff[CTRL_PTOG]) ^ (dm && ctrl_ff[CTRL_DTOG])) begin
				nxt_out = ~out_ff;
			end
		end else begin
			case (os_ff)
				TCC_OS_IDLE: begin
					if (osp_trig) begin
						nxt_os = TCC_OS_WAIT;
					end
				end
				TCC_OS_WAIT: begin
					if (dm) begin
						nxt_os  = TCC_OS_PULSE;
						nxt_out = 1'b1;
					end
				end
				TCC_OS_PULSE: begin
					if (pm) begin
						nxt_os  = TCC_OS_IDLE;
						nxt_out = 1'b0;
					end
				end
				default: nxt_os = TCC_OS_IDLE;
			endcase
		end
		nxt_pirq = pm | (c0i_ff & rise_tick);
		nxt_dirq = dm | (c1i_ff & rise_tick);
	end

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	always_comb begin
		nxt_ctrl   = ctrl_ff;
		nxt_presc  = presc_ff;
		nxt_period = period_ff;
		nxt_duty   = duty_ff;
		if (wr_ctrl) begin
			nxt_ctrl = WR_DATA_I & ~(16'h0001 << CTRL_OSP_SW);
		end
		if (WR_EN_I && (ADDR_I == ADDR_PRESC)) begin
			nxt_presc = WR_DATA_I;
		end
		// Capture has priority over a software write or read
		if (c0_latch) begin
			nxt_period = count_ff;
		end else if (WR_EN_I && (ADDR_I == ADDR_PERIOD)) begin
			nxt_period = WR_DATA_I;
		end
		if (c1_latch) begin
			nxt_duty = count_ff;
		end else if (WR_EN_I && (ADDR_I == ADDR_DUTY)) begin
			nxt_duty = WR_DATA_I;
		end
		// Write-one-to-clear; a set in the same cycle wins
		nxt_ovf = ovf_set | (ovf_ff & ~(wr_stat & WR_DATA_I[ST_OVF]));
		nxt_pif = nxt_pirq | (pif_ff & ~(wr_stat & WR_DATA_I[ST_PIF]));
		nxt_dif = nxt_dirq | (dif_ff & ~(wr_stat & WR_DATA_I[ST_DIF]));
		nxt_rd = '0;
		if (RD_EN_I) begin
			case (ADDR_I)
				ADDR_CTRL:   nxt_rd = ctrl_ff;
				ADDR_PRESC:  nxt_rd = presc_ff;
				ADDR_COUNT:  nxt_rd = count_ff;
				ADDR_PERIOD: nxt_rd = period_ff;
				ADDR_DUTY:   nxt_rd = duty_ff;
				ADDR_STATUS: nxt_rd = {12'h000, out_ff, dif_ff, pif_ff, ovf_ff};
				default:     nxt_rd = '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Flip-flops
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			ctrl_ff   <= CTRL_RST;
			presc_ff  <= PRESC_RST;
			count_ff  <= '0;
			period_ff <= CC_RST;
			duty_ff   <= CC_RST;
			ovf_ff    <= 1'b0;
			pif_ff    <= 1'b0;
			dif_ff    <= 1'b0;
			div_ff    <= '0;
			cclk_ff   <= 1'b0;
			sa1_ff    <= 1'b0;
			sa2_ff    <= 1'b0;
			lva_ff    <= 1'b0;
			sb1_ff    <= 1'b0;
			sb2_ff    <= 1'b0;
			lvb_ff    <= 1'b0;
			seen_ff   <= 1'b0;
			c0p_ff    <= 1'b0;
			c1p_ff    <= 1'b0;
			c0i_ff    <= 1'b0;
			c1i_ff    <= 1'b0;
			out_ff    <= 1'b0;
			pirq_ff   <= 1'b0;
			dirq_ff   <= 1'b0;
			rd_ff     <= '0;
			os_ff     <= TCC_OS_IDLE;
		end else begin
			ctrl_ff   <= nxt_ctrl;
			presc_ff  <= nxt_presc;
			count_ff  <= nxt_count;
			period_ff <= nxt_period;
			duty_ff   <= nxt_duty;
			ovf_ff    <= nxt_ovf;
			pif_ff    <= nxt_pif;
			dif_ff    <= nxt_dif;
			div_ff    <= nxt_div;
			cclk_ff   <= nxt_cclk;
			sa1_ff    <= nxt_sa1;
			sa2_ff    <= nxt_sa2;
			lva_ff    <= nxt_lva;
			sb1_ff    <= nxt_sb1;
			sb2_ff    <= nxt_sb2;
			lvb_ff    <= nxt_lvb;
			seen_ff   <= nxt_seen;
			c0p_ff    <= nxt_c0p;
			c1p_ff    <= nxt_c1p;
			c0i_ff    <= nxt_c0i;
			c1i_ff    <= nxt_c1i;
			out_ff    <= nxt_out;
			pirq_ff   <= nxt_pirq;
			dirq_ff   <= nxt_dirq;
			rd_ff     <= nxt_rd;
			os_ff     <= nxt_os;
		end
	end

	assign RD_DATA_O           = rd_ff;
	assign TOGGLE_OUTPUT_PIN_O = out_ff;
	assign PERIOD_MATCH_IRQ_O  = pirq_ff;
	assign DUTY_MATCH_IRQ_O    = dirq_ff;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	stop_ignores_pins_a: assert property (@(posedge CLK_SYS_I)
		disable iff (!RST_N_I)
		!running |=> (!c0p_ff && !c1p_ff && ($past(WR_EN_I)
			|| ($stable(period_ff) && $stable(duty_ff)))))
		else $error("capture pending while stopped");

	overflow_wrap_a: assert property (@(posedge CLK_SYS_I)
		disable iff (!RST_N_I)
		(cnt_tick && !trig_clr && count_ff == COUNT_MAX)
		|=> (ovf_ff && count_ff == 16'h0000))
		else $error("wrap without overflow flag");

	ext_no_capture_a: assert property (@(posedge CLK_SYS_I)
		disable iff (!RST_N_I)
		ext |-> !cap1_set)
		else $error("capture on count source pin");

	both_edge_skip_a: assert property (@(posedge CLK_SYS_I)
		disable iff (!RST_N_I)
		(presc_ff[PRE_EDGE_A_LSB +: 2] == 2'h3) |-> !cap1_set)
		else $error("capture with both edges selected");

	capture_latch_a: assert property (@(posedge CLK_SYS_I)
		disable iff (!RST_N_I)
		(c1p_ff && fall_tick && running)
		|=> (duty_ff == $past(count_ff)) ##0 c1i_ff)
		else $error("capture did not latch the count");

	oneshot_mode_a: assert property (@(posedge CLK_SYS_I)
		disable iff (!RST_N_I)
		(mode == TCC_CS_MATCH) |=> (os_ff == TCC_OS_IDLE))
		else $error("one-shot active in period-match mode");

	count_step_a: assert property (@(posedge CLK_SYS_I)
		disable iff (!RST_N_I)
		(cnt_tick && !trig_clr && mode != TCC_CS_MATCH)
		|=> count_ff == $past(count_ff) + 16'h0001)
		else $error("counter did not step by one");

	read_no_capture_a: assert property (@(posedge CLK_SYS_I)
		disable iff (!RST_N_I)
		(RD_EN_I && ADDR_I == ADDR_COUNT && !c1_latch)
		|=> $stable(duty_ff))
		else $error("count read changed the duty register");

	filter_two_a: assert property (@(posedge CLK_SYS_I)
		disable iff (!RST_N_I)
		rise_a |-> (sa1_ff && sa2_ff && $past(samp_a)))
		else $error("edge taken without two samples");

endmodule : tcc_timer

// [dv/tcc_pin_driver.sv]
module tcc_pin_driver #(
	parameter int HOLD = 80
) (
	input  wire logic clk_i,
	input  wire logic fire_a_i,
	input  wire logic fire_b_i,
	input  wire logic hold_b_i,
	output logic      pin_a_o,
	output logic      pin_b_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int ca = 0;
	int cb = 0;
	// Pulses of 80 clocks, longer than two count clocks (64), even at the slowest ratio
	always @(posedge clk_i) begin
		ca <= fire_a_i ? HOLD : (ca > 0 ? ca - 1 : 0);
		cb <= fire_b_i ? HOLD : (cb > 0 ? cb - 1 : 0);
	end
	assign pin_a_o = (ca > 0);
	assign pin_b_o = (cb > 0) | hold_b_i;
endmodule : tcc_pin_driver

// [dv/timer16_capture_compare_rules_bench.sv]
module timer16_capture_compare_rules_bench
	import tcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] FREE = 16'(TCC_FREE);
	localparam logic [15:0] CC0  = 16'h1 << CTRL_CC0_CAP;
	localparam logic [15:0] CC1  = 16'h1 << CTRL_CC1_CAP;
	localparam logic [15:0] OSP  = 16'h3 << CTRL_OSP_EN;
	localparam logic [15:0] OSE  = 16'h1 << CTRL_OSP_EN;
	localparam logic [15:0] PTG  = 16'h1 << CTRL_PTOG;
	localparam logic [15:0] ERB  = 16'(TCC_EDGE_RISE) << PRE_EDGE_B_LSB;
	localparam logic [15:0] ERA  = 16'(TCC_EDGE_RISE) << PRE_EDGE_A_LSB;
	localparam logic [15:0] EBA  = 16'(TCC_EDGE_BOTH) << PRE_EDGE_A_LSB;
	logic        clk   = 1'b0;
	logic        rst_n = 1'b0;
	logic [2:0]  addr  = 3'h0;
	logic [15:0] wdat  = 16'h0000;
	logic        we    = 1'b0;
	logic        re    = 1'b0;
	logic [15:0] rdat;
	logic        pa, pb, tog, pirq, dirq;
	logic        fa    = 1'b0;
	logic        fb    = 1'b0;
	logic        hb    = 1'b0;
	logic        tog_q = 1'b0;
	int          failures = 0;
	int          n_compared = 0;
	int          p_cnt = 0, d_cnt = 0, o_cnt = 0;
	int          mdl [8];
	logic [15:0] c0, c1, v;
	int          r, p0, d0, o0;

	tcc_timer i_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
		.WR_DATA_I(wdat), .WR_EN_I(we), .RD_EN_I(re), .RD_DATA_O(rdat),
		.TRIGGER_INPUT_A_I(pa), .TRIGGER_INPUT_B_I(pb),
		.TOGGLE_OUTPUT_PIN_O(tog), .PERIOD_MATCH_IRQ_O(pirq),
		.DUTY_MATCH_IRQ_O(dirq));
	tcc_pin_driver i_pins (.clk_i(clk), .fire_a_i(fa), .fire_b_i(fb),
		.hold_b_i(hb), .pin_a_o(pa), .pin_b_o(pb));

	initial begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (pirq === 1'b1) p_cnt++;
		if (dirq === 1'b1) d_cnt++;
		if (tog === 1'b1 && tog_q !== 1'b1) o_cnt++;
		tog_q = tog;
	end

	// ------------------------------------------------------------
	// Bus, pin and check tasks
	// ------------------------------------------------------------
	task give_verdict();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict
	task chk(input string nm, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
		// The model keeps only what software may read back
		if (a == ADDR_PERIOD || a == ADDR_DUTY) mdl[a] = d;
	endtask : wr
	task rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 d = rdat;
	endtask : rd
	task rdc(input string nm, input logic [2:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		chk(nm, d, e);
	endtask : rdc
	task fire(input bit a);
		@(posedge clk);
		if (a) fa <= 1'b1;
		else fb <= 1'b1;
		@(posedge clk);
		fa <= 1'b0;
		fb <= 1'b0;
		repeat (100) @(posedge clk);
	endtask : fire
	task automatic wait_inc(ref int c, input int c_old, input string nm);
		int i = 0;
		while (c == c_old && i < 300) begin
			@(posedge clk);
			i++;
		end
		if (c == c_old) begin
			failures++;
			$display("CHECK FAILED %s expected event seen none", nm);
			give_verdict();
		end
	endtask : wait_inc
	task reset();
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		foreach (mdl[i]) mdl[i] = 0;
	endtask : reset

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(85));
		reset();
		for (int a = 0; a < 8; a++) rdc("reset value", 3'(a), 16'h0000);
		wr(ADDR_PERIOD, 16'h1234);
		wr(ADDR_PRESC, ERB);
		wr(ADDR_CTRL, CC0);
		p0 = p_cnt;
		fire(0);
		rdc("period while stopped", ADDR_PERIOD, 16'(mdl[3]));
		chk("irq while stopped", 16'(p_cnt), 16'(p0));
		wr(ADDR_COUNT, 16'h5555);
		rdc("count write", ADDR_COUNT, 16'h0000);
		wr(ADDR_CTRL, FREE);
		for (int k = 0; k < 3; k++) begin
			r = $urandom_range(60, 10);
			rd(ADDR_COUNT, c0);
			repeat (2 * r) @(posedge clk);
			rd(ADDR_COUNT, c1);
			chk("count rate", c1 - c0, 16'(r + 1));
		end
		wr(ADDR_DUTY, 16'h8000 | 16'($urandom));
		wr(ADDR_CTRL, FREE | CC1);
		d0 = d_cnt;
		repeat (4) rd(ADDR_COUNT, c0);
		rdc("duty after count read", ADDR_DUTY, 16'(mdl[4]));
		chk("duty irq on read", 16'(d_cnt), 16'(d0));
		wr(ADDR_CTRL, FREE | CC0);
		p0 = p_cnt;
		rd(ADDR_COUNT, c0);
		fire(0);
		wait_inc(p_cnt, p0, "capture irq");
		rd(ADDR_PERIOD, v);
		chk("capture lag", 16'(v - c0 > 0 && v - c0 < 90), 16'h1);
		rd(ADDR_STATUS, c1);
		chk("period flag", 16'(c1[ST_PIF]), 16'h1);
		wr(ADDR_STATUS, 16'h1 << ST_PIF);
		rd(ADDR_STATUS, c1);
		chk("period flag clear", 16'(c1[ST_PIF]), 16'h0);
		wr(ADDR_CTRL, CC0);
		wr(ADDR_PERIOD, 16'h2468);
		p0 = p_cnt;
		fire(0);
		rdc("capture after stop", ADDR_PERIOD, 16'(mdl[3]));
		chk("irq after stop", 16'(p_cnt), 16'(p0));
		wr(ADDR_PERIOD, 16'hfff0);
		wr(ADDR_CTRL, FREE);
		p0 = p_cnt;
		fire(0);
		rdc("compare mode", ADDR_PERIOD, 16'(mdl[3]));
		chk("compare irq", 16'(p_cnt), 16'(p0));
		wr(ADDR_CTRL, 16'h0);
		wr(ADDR_DUTY, 16'h0777);
		wr(ADDR_PRESC, EBA);
		wr(ADDR_CTRL, FREE | CC1);
		d0 = d_cnt;
		fire(1);
		rdc("both edges", ADDR_DUTY, 16'(mdl[4]));
		chk("both edges irq", 16'(d_cnt), 16'(d0));
		wr(ADDR_CTRL, 16'h0);
		wr(ADDR_PRESC, ERA | 16'(CLK_SEL_EXT));
		wr(ADDR_CTRL, FREE | CC1);
		repeat (3) fire(1);
		rdc("pin clock count", ADDR_COUNT, 16'h0003);
		rdc("pin clock capture", ADDR_DUTY, 16'(mdl[4]));
		chk("pin clock irq", 16'(d_cnt), 16'(d0));
		wr(ADDR_CTRL, 16'h0);
		wr(ADDR_PRESC, 16'h0);
		wr(ADDR_DUTY, 16'h0004);
		wr(ADDR_PERIOD, 16'h0008);
		o0 = o_cnt;
		wr(ADDR_CTRL, 16'(TCC_CS_MATCH) | OSE);
		wr(ADDR_CTRL, 16'(TCC_CS_MATCH) | OSP);
		repeat (100) @(posedge clk);
		chk("one-shot in match mode", 16'(o_cnt), 16'(o0));
		wr(ADDR_CTRL, 16'h0);
		wr(ADDR_CTRL, FREE | OSE);
		wr(ADDR_CTRL, FREE | OSP);
		wait_inc(o_cnt, o0, "one-shot pulse");
		repeat (100) @(posedge clk);
		chk("one-shot end", 16'(tog), 16'h0);
		wr(ADDR_CTRL, FREE);
		rd(ADDR_COUNT, c0);
		wr(ADDR_PERIOD, c0 + 16'($urandom_range(90, 60)));
		repeat (2) @(posedge clk);
		rd(ADDR_COUNT, v);
		chk("count during change", v - c0, 16'h0003);
		o0 = o_cnt;
		wr(ADDR_CTRL, FREE | PTG);
		wr(ADDR_STATUS, 16'h1 << ST_PIF);
		wait_inc(o_cnt, o0, "period toggle");
		rdc("period after change", ADDR_PERIOD, 16'(mdl[3]));
		rd(ADDR_STATUS, c1);
		chk("period flag after change", 16'(c1[ST_PIF]), 16'h1);
		wr(ADDR_CTRL, 16'h0);
		hb <= 1'b1;
		reset();
		wr(ADDR_PRESC, ERB);
		p0 = p_cnt;
		wr(ADDR_CTRL, FREE | CC0);
		wait_inc(p_cnt, p0, "edge at first start");
		wr(ADDR_CTRL, 16'h0);
		p0 = p_cnt;
		wr(ADDR_CTRL, FREE | CC0);
		repeat (200) @(posedge clk);
		chk("edge at restart", 16'(p_cnt), 16'(p0));
		hb <= 1'b0;
		give_verdict();
	end
	initial begin
		repeat (90000) @(posedge clk);
		failures++;
		$display("CHECK FAILED run length expected end seen none");
		give_verdict();
	end
endmodule : timer16_capture_compare_rules_bench
